// ===== hw/stop_sel_pkg.sv
// package: constants, register map and carriers for the servo stop-policy selector
// assumes: axi4-lite register access, single 10 MHz clock
package stop_sel_pkg;
   // ******************************
   // clock and timing
   // ******************************
   localparam int unsigned CLK_HZ          = 10_000_000;
   localparam int unsigned MS_UNIT         = 1;
   localparam int unsigned CYC_PER_MS      = CLK_HZ / 1000 * MS_UNIT;
   // ******************************
   // register offsets (byte addresses)
   // ******************************
   localparam logic [7:0] OFF_PROHIBIT_SEL  = 8'h00;
   localparam logic [7:0] OFF_PROHIBIT_STOP = 8'h04;
   localparam logic [7:0] OFF_SERVO_OFF     = 8'h08;
   localparam logic [7:0] OFF_POWER_LOSS    = 8'h0c;
   localparam logic [7:0] OFF_UV_SEL        = 8'h10;
   localparam logic [7:0] OFF_HOLD_TIME     = 8'h14;
   localparam logic [7:0] OFF_ALARM_STOP    = 8'h18;
   localparam logic [7:0] OFF_STATE         = 8'h1c;
   localparam logic [7:0] OFF_IRQ_STATUS    = 8'h20;
   localparam logic [7:0] OFF_IRQ_ENABLE    = 8'h24;
   localparam logic [7:0] OFF_IRQ_CLEAR     = 8'h28;
   // ******************************
   // reset values and ranges
   // ******************************
   localparam logic [1:0]  RST_PROHIBIT_SEL  = 2'h1;
   localparam logic [1:0]  MAX_PROHIBIT_SEL  = 2'h2;
   localparam logic [1:0]  RST_PROHIBIT_STOP = 2'h0;
   localparam logic [1:0]  MAX_PROHIBIT_STOP = 2'h2;
   localparam logic [3:0]  RST_STOP_CODE     = 4'h0;
   localparam logic [3:0]  MAX_STOP_CODE     = 4'h9;
   localparam logic [2:0]  RST_ALARM_CODE    = 3'h0;
   localparam logic        RST_UV_SEL        = 1'b1;
   localparam logic [10:0] RST_HOLD_MS       = 11'd70;
   localparam logic [10:0] MIN_HOLD_MS       = 11'd70;
   localparam logic [10:0] MAX_HOLD_MS       = 11'd2000;
   localparam logic [7:0]  UV_ALARM_CODE     = 8'hd1;   // alarm 13.1 as bcd-ish 0xd.1
   localparam int unsigned IRQ_BITS          = 3;
   // ******************************
   // types
   // ******************************
   typedef enum logic [1:0] {
      DECEL_DB   = 2'h0,
      DECEL_FREE = 2'h1,
      DECEL_ESTP = 2'h2
   } decel_e;
   typedef enum logic {
      HOLD_DB   = 1'b0,
      HOLD_FREE = 1'b1
   } hold_e;
   typedef struct packed {
      decel_e decel;
      hold_e  hold;
      logic   clr_err;
   } stop_act_s;
   typedef struct packed {
      logic fwd_block;
      logic rev_block;
      logic active;
   } prohibit_s;
endpackage

// ===== hw/stop_sel_hold.sv
// holdoff timer: main-power loss must persist for the programmed time before it counts
// assumes: power_low synchronous to aclk, hold_ms already range-checked
`timescale 1ns/100ps
module stop_sel_hold
   import stop_sel_pkg::*;
#(
   parameter int unsigned CYC_MS = CYC_PER_MS
) (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        power_low,
   input  wire logic [10:0] hold_ms,
   output logic             fault
);
   initial begin
      if (CYC_MS < 1) $error("CYC_MS must be at least 1");
   end

   logic [23:0] cyc;
   logic [10:0] ms;

   // ******************************
   // detection window
   // ******************************
   always_ff @(posedge aclk) begin
      if (!aresetn || !power_low) begin
         cyc <= 24'h0;
         ms  <= 11'h0;
      end else if (!fault) begin
         if (cyc == 24'(CYC_MS - 1)) begin
            cyc <= 24'h0;
            ms  <= ms + 11'h1;
         end else begin
            cyc <= cyc + 24'h1;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn || !power_low) begin
         fault <= 1'b0;
      end else if (ms >= hold_ms) begin
         fault <= 1'b1;
      end
   end

   hold_count_a: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(fault) |-> $past(power_low) && ms >= hold_ms)
      else $error("power fault raised before hold time");
endmodule // stop_sel_hold

// ===== hw/stop_sel_top.sv
// stop-policy selector: picks deceleration and hold reaction per trigger
// assumes: axi4-lite master, synchronous trigger inputs, one 10 MHz clock
// Function
// - prohibit selection takes 0..2, resets to 1, codes 0 and 2 enable both limit inputs.
// - prohibit stop option 0 removes torque that way and applies the dynamic brake.
// - prohibit stop option 1 removes torque that way and lets the motor coast.
// - prohibit stop option 2 removes torque that way and makes an emergency stop.
// - servo-off codes 0..7 pair brake or coast deceleration with brake or free hold.
// - servo-off codes 8 and 9 decelerate by emergency stop, holding brake or free.
// - every servo-off code clears the position error counter.
// - the power-loss stop code uses the servo-off code set and meaning, reset 0.
// - undervoltage selection 0 turns a power fault into servo-off, resumed on recovery.
// - undervoltage selection 1, the reset value, raises alarm 13.1 and stops.
// - power fault detection time is set in 1 ms steps from 70 to 2000, reset 70.
// - alarm codes 0..3 follow servo-off pairings 0..3, range 0..7, reset 0.
// - alarm codes 4..7 emergency stop on e-stop class alarms, others act like codes 0..3.
`timescale 1ns/100ps
module stop_sel_top
   import stop_sel_pkg::*;
#(
   parameter int unsigned CYC_MS = CYC_PER_MS
) (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        servo_on_req,
   input  wire logic        fwd_limit,
   input  wire logic        rev_limit,
   input  wire logic        main_power_low,
   input  wire logic        alarm,
   input  wire logic        alarm_estop_class,
   output logic             servo_enable,
   output logic [1:0]       decel_mode,
   output logic             hold_free,
   output logic             clr_err_count,
   output logic             fwd_torque_block,
   output logic             rev_torque_block,
   output logic             uv_alarm,
   output logic [7:0]       alarm_code,
   output logic             irq
);
   initial begin
      if (CYC_MS < 1) $error("CYC_MS must be at least 1");
   end
   // ******************************
   // decode helpers
   // ******************************
   function automatic stop_act_s stop_code_act(input logic [3:0] c);
      stop_act_s a;
      a.clr_err = 1'b1;
      if (c >= 4'h8) begin
         a.decel = DECEL_ESTP;
         a.hold  = c[0] ? HOLD_FREE : HOLD_DB;
      end else begin
         a.decel = c[0] ? DECEL_FREE : DECEL_DB;
         a.hold  = c[1] ? HOLD_FREE : HOLD_DB;
      end
      return a;
   endfunction
   function automatic logic wr_hit(input logic [7:0] a, input logic [7:0] off);
      return a[7:2] == off[7:2];
   endfunction
   // ******************************
   // settings registers
   // ******************************
   logic [1:0]  prohibit_sel;
   logic [1:0]  prohibit_stop;
   logic [3:0]  servo_off_stop_select;
   logic [3:0]  power_loss_stop_select;
   logic        uv_sel;
   logic [10:0] hold_ms;
   logic [2:0]  alarm_stop_select;
   logic [IRQ_BITS-1:0] irq_status;
   logic [IRQ_BITS-1:0] irq_enable;
   logic        aw_held;
   logic        w_held;
   logic [7:0]  aw_addr;
   logic [31:0] w_data;
   logic [3:0]  w_strb;
   logic        do_write;
   logic        bad_wr;
   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready  = !w_held && !s_axi_bvalid;
   assign do_write      = aw_held && w_held && !s_axi_bvalid;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         aw_addr <= 8'h0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held <= 1'b1;
         aw_addr <= s_axi_awaddr;
      end else if (do_write) begin
         aw_held <= 1'b0;
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held <= 1'b0;
         w_data <= 32'h0;
         w_strb <= 4'h0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held <= 1'b1;
         w_data <= s_axi_wdata;
         w_strb <= s_axi_wstrb;
      end else if (do_write) begin
         w_held <= 1'b0;
      end
   end
   assign bad_wr = !(wr_hit(aw_addr, OFF_PROHIBIT_SEL) || wr_hit(aw_addr, OFF_PROHIBIT_STOP) ||
                     wr_hit(aw_addr, OFF_SERVO_OFF) || wr_hit(aw_addr, OFF_POWER_LOSS) ||
                     wr_hit(aw_addr, OFF_UV_SEL) || wr_hit(aw_addr, OFF_HOLD_TIME) ||
                     wr_hit(aw_addr, OFF_ALARM_STOP) || wr_hit(aw_addr, OFF_IRQ_ENABLE) ||
                     wr_hit(aw_addr, OFF_IRQ_CLEAR));
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= 2'h0;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= bad_wr ? 2'h2 : 2'h0;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // out-of-range values are ignored so the last legal setting stays in force
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         prohibit_sel           <= RST_PROHIBIT_SEL;
         prohibit_stop          <= RST_PROHIBIT_STOP;
         servo_off_stop_select  <= RST_STOP_CODE;
         power_loss_stop_select <= RST_STOP_CODE;
         uv_sel                 <= RST_UV_SEL;
         hold_ms                <= RST_HOLD_MS;
         alarm_stop_select      <= RST_ALARM_CODE;
         irq_enable             <= '0;
      end else if (do_write && w_strb[0]) begin
         if (wr_hit(aw_addr, OFF_PROHIBIT_SEL) && w_data[7:0] <= 8'(MAX_PROHIBIT_SEL)) begin
            prohibit_sel <= w_data[1:0];
         end
         if (wr_hit(aw_addr, OFF_PROHIBIT_STOP) && w_data[7:0] <= 8'(MAX_PROHIBIT_STOP)) begin
            prohibit_stop <= w_data[1:0];
         end
         if (wr_hit(aw_addr, OFF_SERVO_OFF) && w_data[7:0] <= 8'(MAX_STOP_CODE)) begin
            servo_off_stop_select <= w_data[3:0];
         end
         if (wr_hit(aw_addr, OFF_POWER_LOSS) && w_data[7:0] <= 8'(MAX_STOP_CODE)) begin
            power_loss_stop_select <= w_data[3:0];
         end
         if (wr_hit(aw_addr, OFF_UV_SEL) && w_data[7:1] == 7'h0) begin
            uv_sel <= w_data[0];
         end
         if (wr_hit(aw_addr, OFF_ALARM_STOP) && w_data[7:3] == 5'h0) begin
            alarm_stop_select <= w_data[2:0];
         end
         if (wr_hit(aw_addr, OFF_IRQ_ENABLE)) begin
            irq_enable <= w_data[IRQ_BITS-1:0];
         end
         if (wr_hit(aw_addr, OFF_HOLD_TIME) && w_strb[1] && w_data[31:11] == 21'h0 &&
             w_data[10:0] >= MIN_HOLD_MS && w_data[10:0] <= MAX_HOLD_MS) begin
            hold_ms <= w_data[10:0];
         end
      end
   end

   // ******************************
   // trigger evaluation
   // ******************************
   logic      power_fault;
   prohibit_s prohibit;
   stop_act_s act_off;
   stop_act_s act_pwr;
   stop_act_s act_alm;
   stop_act_s act_pro;
   stop_sel_hold #(
      .CYC_MS    (CYC_MS)
   ) u_hold (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .power_low (main_power_low),
      .hold_ms   (hold_ms),
      .fault     (power_fault)
   );
   always_comb begin
      prohibit.fwd_block = (prohibit_sel != 2'h1) && fwd_limit;
      prohibit.rev_block = (prohibit_sel != 2'h1) && rev_limit;
      prohibit.active    = prohibit.fwd_block || prohibit.rev_block;
      act_off = stop_code_act(servo_off_stop_select);
      act_pwr = stop_code_act(power_loss_stop_select);
      act_alm = stop_code_act({2'h0, alarm_stop_select[1:0]});
      act_alm.clr_err = 1'b0;
      if (alarm_stop_select[2] && alarm_estop_class) begin
         act_alm.decel = DECEL_ESTP;
      end
      act_pro.clr_err = 1'b0;
      case (prohibit_stop)
         2'h0:    act_pro.decel = DECEL_DB;
         2'h1:    act_pro.decel = DECEL_FREE;
         2'h2:    act_pro.decel = DECEL_ESTP;
         default: act_pro.decel = DECEL_DB;
      endcase
      act_pro.hold = (prohibit_stop == 2'h1) ? HOLD_FREE : HOLD_DB;
   end

   // ******************************
   // uv alarm latch
   // ******************************
   // latched so the drive stays stopped until reset, even after power returns
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         uv_alarm <= 1'b0;
      end else if (power_fault && uv_sel) begin
         uv_alarm <= 1'b1;
      end
   end
   logic alarm_any;
   assign alarm_any = alarm || uv_alarm;
   // ******************************
   // stop action selection
   // ******************************
   stop_act_s next_act;
   logic      next_enable;
   always_comb begin
      next_enable = 1'b1;
      next_act    = '{decel: DECEL_DB, hold: HOLD_DB, clr_err: 1'b0};
      if (alarm_any) begin
         next_enable = 1'b0;
         next_act    = act_alm;
      end else if (power_fault && !uv_sel) begin
         next_enable = 1'b0;
         next_act    = act_pwr;
      end else if (!servo_on_req) begin
         next_enable = 1'b0;
         next_act    = act_off;
      end else if (prohibit.active) begin
         next_act    = act_pro;
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         servo_enable     <= 1'b0;
         decel_mode       <= DECEL_DB;
         hold_free        <= 1'b0;
         clr_err_count    <= 1'b0;
         fwd_torque_block <= 1'b0;
         rev_torque_block <= 1'b0;
         alarm_code       <= 8'h0;
      end else begin
         servo_enable     <= next_enable;
         decel_mode       <= next_act.decel;
         hold_free        <= next_act.hold == HOLD_FREE;
         clr_err_count    <= next_act.clr_err;
         fwd_torque_block <= prohibit.fwd_block;
         rev_torque_block <= prohibit.rev_block;
         alarm_code       <= uv_alarm ? UV_ALARM_CODE : 8'h0;
      end
   end

   // ******************************
   // interrupts: 0 power fault, 1 alarm, 2 prohibit
   // ******************************
   logic [IRQ_BITS-1:0] irq_event;
   logic [IRQ_BITS-1:0] irq_clr;
   assign irq_event = {prohibit.active, alarm_any, power_fault};
   assign irq_clr   = (do_write && wr_hit(aw_addr, OFF_IRQ_CLEAR)) ? w_data[IRQ_BITS-1:0] : '0;
   // a new event in the clear cycle wins
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_status <= '0;
      end else begin
         irq_status <= (irq_status & ~irq_clr) | irq_event;
      end
   end
   assign irq = |(irq_status & irq_enable);
   // ******************************
   // read channel
   // ******************************
   logic [31:0] rd_val;
   always_comb begin
      case (s_axi_araddr[7:2])
         OFF_PROHIBIT_SEL[7:2]:  rd_val = {30'h0, prohibit_sel};
         OFF_PROHIBIT_STOP[7:2]: rd_val = {30'h0, prohibit_stop};
         OFF_SERVO_OFF[7:2]:     rd_val = {28'h0, servo_off_stop_select};
         OFF_POWER_LOSS[7:2]:    rd_val = {28'h0, power_loss_stop_select};
         OFF_UV_SEL[7:2]:        rd_val = {31'h0, uv_sel};
         OFF_HOLD_TIME[7:2]:     rd_val = {21'h0, hold_ms};
         OFF_ALARM_STOP[7:2]:    rd_val = {29'h0, alarm_stop_select};
         OFF_STATE[7:2]:         rd_val = {18'h0, alarm_code, uv_alarm, clr_err_count,
                                           hold_free, decel_mode, servo_enable};
         OFF_IRQ_STATUS[7:2]:    rd_val = {29'h0, irq_status};
         OFF_IRQ_ENABLE[7:2]:    rd_val = {29'h0, irq_enable};
         default:                rd_val = 32'h0;
      endcase
   end
   assign s_axi_arready = !s_axi_rvalid;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0;
         s_axi_rresp  <= 2'h0;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rd_val;
         s_axi_rresp  <= (s_axi_araddr[7:2] >= OFF_IRQ_CLEAR[7:2]) ? 2'h2 : 2'h0;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ******************************
   // checks
   // ******************************
   prohibit_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
      prohibit_sel == 2'h1 |=> !fwd_torque_block && !rev_torque_block)
      else $error("prohibit input acted while disabled");
   prohibit_brake_a: assert property (@(posedge aclk) disable iff (!aresetn)
      servo_on_req && !alarm_any && !power_fault && prohibit.active && prohibit_stop == 2'h0
      |=> decel_mode == DECEL_DB)
      else $error("prohibit stop option 0 did not brake");
   prohibit_coast_a: assert property (@(posedge aclk) disable iff (!aresetn)
      servo_on_req && !alarm_any && !power_fault && prohibit.active && prohibit_stop == 2'h1
      |=> decel_mode == DECEL_FREE)
      else $error("prohibit stop option 1 did not coast");
   prohibit_estop_a: assert property (@(posedge aclk) disable iff (!aresetn)
      servo_on_req && !alarm_any && !power_fault && prohibit.active && prohibit_stop == 2'h2
      |=> decel_mode == DECEL_ESTP)
      else $error("prohibit stop option 2 did not emergency stop");
   servo_off_map_a: assert property (@(posedge aclk) disable iff (!aresetn)
      !servo_on_req && !alarm_any && !power_fault && servo_off_stop_select < 4'h8
      |=> decel_mode == {1'b0, $past(servo_off_stop_select[0])}
          && hold_free == $past(servo_off_stop_select[1]))
      else $error("servo-off code mapping wrong");
   servo_off_estop_a: assert property (@(posedge aclk) disable iff (!aresetn)
      !servo_on_req && !alarm_any && !power_fault && servo_off_stop_select >= 4'h8
      |=> decel_mode == DECEL_ESTP && hold_free == $past(servo_off_stop_select[0]))
      else $error("servo-off code 8 or 9 wrong");
   err_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
      !servo_on_req && !alarm_any |=> clr_err_count)
      else $error("servo-off did not clear error counter");
   uv_servo_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
      power_fault && !uv_sel && !alarm_any |=> !servo_enable && !uv_alarm)
      else $error("undervoltage selection 0 did not servo off");
   uv_alarm_a: assert property (@(posedge aclk) disable iff (!aresetn)
      power_fault && uv_sel |=> uv_alarm ##1 !servo_enable && alarm_code == UV_ALARM_CODE)
      else $error("undervoltage alarm not raised");
   alarm_first_a: assert property (@(posedge aclk) disable iff (!aresetn)
      alarm |=> !servo_enable && !clr_err_count)
      else $error("alarm did not take precedence");
   alarm_estop_a: assert property (@(posedge aclk) disable iff (!aresetn)
      alarm && alarm_stop_select[2] && alarm_estop_class |=> decel_mode == DECEL_ESTP)
      else $error("e-stop class alarm did not emergency stop");
endmodule // stop_sel_top

// ===== tb/power_stage_model.sv
// far-side model: mains switch feeding the drive and the brake it would see
// assumes: one aclk, stop outputs come from the selector
`timescale 1ns/100ps
module power_stage_model (
   input  wire logic       aclk,
   input  wire logic       mains_on,
   input  wire logic       servo_enable,
   input  wire logic [1:0] decel_mode,
   output logic            main_power_low,
   output logic            braking
);
   // mains sense is registered, as a real detector adds a cycle
   always_ff @(posedge aclk) begin
      main_power_low <= !mains_on;
   end
   assign braking = !servo_enable && decel_mode != 2'h1;
endmodule // power_stage_model

// ===== tb/servo_stop_mode_selector_test.sv
// self-checking bench of the stop-policy selector
// assumes: selector built with CYC_MS 2, so one ms is two cycles
`timescale 1ns/100ps
module servo_stop_mode_selector_test;
   import stop_sel_pkg::*;
   logic        aclk = 0, aresetn = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
   logic [7:0]  aa = 8'h00, ra = 8'h00, ac;
   logic [31:0] wd = 32'h0, rd, v;
   logic [1:0]  br, rr, dm, r;
   logic        awr, wr, bv, arr, rv, en, hf, ce, fb, rb, uv, irq, mpl, ta, tb, tw, brk;
   logic        son = 1, fl = 0, rl = 0, al = 0, ae = 0, mains = 1;
   int          bad_count = 0, checks = 0, i, n, pc;
   wire [4:0]   o = {en, dm, hf, ce};
   always #50 aclk = !aclk;
   power_stage_model ps_u (.aclk, .mains_on(mains), .servo_enable(en), .decel_mode(dm),
      .main_power_low(mpl), .braking(brk));
   stop_sel_top #(.CYC_MS(2)) dut_u (.aclk, .aresetn, .s_axi_awaddr(aa), .s_axi_awvalid(awv),
      .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
      .s_axi_wready(wr), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry),
      .s_axi_araddr(ra), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
      .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry), .servo_on_req(son),
      .fwd_limit(fl), .rev_limit(rl), .main_power_low(mpl), .alarm(al),
      .alarm_estop_class(ae), .servo_enable(en), .decel_mode(dm), .hold_free(hf),
      .clr_err_count(ce), .fwd_torque_block(fb), .rev_torque_block(rb), .uv_alarm(uv),
      .alarm_code(ac), .irq(irq));
   // ***********************
   // helpers
   // ***********************
   task automatic finish_test(input bit to);
      if (to) bad_count++;
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] s, e);
      checks++;
      if (s !== e) begin
         bad_count++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   // handshakes are judged at the falling edge, where ready has settled
   task automatic wrt(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      aa <= a;
      wd <= d;
      awv <= 1;
      wv <= 1;
      bry <= 1;
      for (n = 0; n < 40; n++) begin
         @(negedge aclk);
         ta = awv & awr;
         tw = wv & wr;
         tb = bv;
         r = br;
         @(posedge aclk);
         if (ta) awv <= 0;
         if (tw) wv <= 0;
         if (tb) bry <= 0;
         if (tb) break;
      end
      if (n == 40) finish_test(1);
   endtask
   task automatic rdt(input logic [7:0] a);
      @(posedge aclk);
      ra <= a;
      arv <= 1;
      rry <= 1;
      for (n = 0; n < 40; n++) begin
         @(negedge aclk);
         ta = arv & arr;
         tb = rv;
         v = rd;
         r = rr;
         @(posedge aclk);
         if (ta) arv <= 0;
         if (tb) rry <= 0;
         if (tb) break;
      end
      if (n == 40) finish_test(1);
   endtask
   task automatic st;
      repeat (3) @(posedge aclk);
      @(negedge aclk);
   endtask
   function automatic logic [4:0] ex(int e, d, h, c);
      return {e[0], d[1:0], h[0], c[0]};
   endfunction
   function automatic logic [4:0] sc(int c);
      return c < 8 ? ex(0, c % 2, c / 2 % 2, 1) : ex(0, 2, c % 2, 1);
   endfunction
   // ***********************
   // scenarios
   // ***********************
   initial begin
      void'($urandom(98));
      repeat (6) @(posedge aclk);
      aresetn <= 1;
      rdt(OFF_PROHIBIT_SEL);
      chk(v, 1);
      rdt(OFF_UV_SEL);
      chk(v, 1);
      rdt(8'h30);
      chk(r, 2);
      // code 10 is refused, so the last pass still sees code 9
      for (i = 0; i < 11; i++) begin
         wrt(OFF_SERVO_OFF, i);
         @(posedge aclk) son <= 0;
         st;
         chk(o, sc(i < 10 ? i : 9));
         @(posedge aclk) son <= 1;
      end
      for (i = 0; i < 4; i++) begin
         wrt(OFF_PROHIBIT_SEL, i == 3 ? 1 : i == 1 ? 2 : 0);
         wrt(OFF_PROHIBIT_STOP, i % 3);
         @(posedge aclk) fl <= !i[0];
         rl <= i[0];
         st;
         if (i == 3) chk({fb, rb, en}, 3'b001);
         else chk({fb, rb, o}, {!i[0], i[0], ex(1, i, i == 1, 0)});
         @(posedge aclk) fl <= 0;
         rl <= 0;
      end
      @(posedge aclk) son <= 0;
      for (i = 0; i < 16; i++) begin
         wrt(OFF_ALARM_STOP, i / 2);
         @(posedge aclk) al <= 1;
         ae <= i[0];
         st;
         chk(o, ex(0, i >= 8 && i[0] ? 2 : i / 2 % 2, i / 4 % 2, 0));
         @(posedge aclk) al <= 0;
      end
      @(posedge aclk) son <= 1;
      pc = $urandom % 10;
      wrt(OFF_POWER_LOSS, pc);
      wrt(OFF_UV_SEL, 0);
      wrt(OFF_IRQ_ENABLE, 1);
      wrt(OFF_HOLD_TIME, 69);
      chk(r, 0);
      wrt(OFF_IRQ_STATUS, 0);
      chk(r, 2);
      rdt(OFF_HOLD_TIME);
      chk(v, 70);
      @(posedge aclk) mains <= 0;
      repeat (135) @(posedge aclk);
      @(negedge aclk);
      chk(en, 1);
      for (n = 0; n < 40 && en; n++) @(negedge aclk);
      if (en) finish_test(1);
      chk(o, sc(pc));
      chk(irq, 1);
      chk(brk, pc > 7 || pc % 2 == 0);
      @(posedge aclk) mains <= 1;
      st;
      chk(en, 1);
      wrt(OFF_IRQ_CLEAR, 1);
      @(negedge aclk);
      chk(irq, 0);
      wrt(OFF_UV_SEL, 1);
      @(posedge aclk) mains <= 0;
      repeat (150) @(posedge aclk);
      @(negedge aclk);
      chk({uv, ac, en}, {1'b1, UV_ALARM_CODE, 1'b0});
      // mid-run reset: only a reset clears the sticky undervoltage alarm
      @(posedge aclk) aresetn <= 0;
      mains <= 1;
      repeat (2) @(posedge aclk);
      aresetn <= 1;
      rdt(OFF_SERVO_OFF);
      chk(v, 0);
      chk({uv, ac}, 9'h0);
      finish_test(0);
   end
endmodule // servo_stop_mode_selector_test
